// ### inc/modbus_gw_pkg.sv
// constants, register map and carriers for the serial write-multiple handler
package modbus_gw_pkg;
  // timing
  localparam int CLK_HZ = 250_000_000;
  localparam int DEF_BAUD = 115200;
  localparam logic [15:0] DEF_BAUD_DIV = 16'(CLK_HZ / DEF_BAUD);
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic DEF_TWO_STOP = 1'b0;
  localparam logic [7:0] DEF_STATION = 8'h01;

  // frame contents
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [15:0] START_STOP_REF = 16'h07D8;
  localparam logic [15:0] SEND_START_VAL = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int RESP_LEN = 8;
  localparam int RESP_CRC_LO = 6;
  localparam int RESP_CRC_HI = 7;

  // apb byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] SERIAL_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] MASK_OFS = 12'h00C;
  localparam logic [11:0] INTERVAL_OFS = 12'h010;
  localparam logic [11:0] INFO_OFS = 12'h014;
  localparam logic [11:0] TABLE_OFS = 12'h040;

  // event bits of status and mask
  localparam int EV_FRAME_OK = 0;
  localparam int EV_CRC_ERR = 1;
  localparam int EV_FORMAT_ERR = 2;
  localparam int EV_BUS_OFF = 3;
  localparam int EV_W = 4;

  typedef struct packed {
    logic [7:0] station_number;
    logic swap_en;
    logic busoff_rst_en;
  } ctrl_s;

  typedef struct packed {
    logic [15:0] baud_div;
    logic [1:0] parity;
    logic two_stop;
  } ser_cfg_s;

  localparam ctrl_s CTRL_RESET = '{station_number: DEF_STATION, swap_en: 1'b0,
                                   busoff_rst_en: 1'b0};
  localparam ser_cfg_s SER_DEFAULT = '{baud_div: DEF_BAUD_DIV, parity: PARITY_NONE,
                                       two_stop: DEF_TWO_STOP};

  typedef enum logic [3:0] {
    S_ADDR, S_FC, S_REF_HI, S_REF_LO, S_CNT_HI, S_CNT_LO, S_BCNT, S_DATA,
    S_CRC_LO, S_CRC_HI, S_SKIP, S_RESP
  } parse_e;
endpackage

// ### hw/modbus_write_port.sv
// serial write-multiple-register command handler with apb control
// Notes on behaviour
// - request: station byte, function 0x10, two-byte reference, two-byte word count
// - seventh byte is byte count; must equal twice word count, checked
// - payload follows byte count, two bytes per word, bytes 7 to B+6
// - two check bytes follow payload at B+7 and B+8
// - good write answered with echoed header and fresh check value
// - first connection uses 115200 baud, no parity, one stop, station 1
// - after first connection the stored serial settings apply instead
// - bus-off with recovery enabled resets the CAN controller automatically
// - swap option exchanges the two bytes of each data word
// - operating mode only when selector reads normal at power-up
// - output table words are sent cyclically at the update interval
// - writing 0 to start/stop reference starts sending, 1 stops it
module modbus_write_port
  import modbus_gw_pkg::*;
#(
  parameter int WORDS = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  // serial byte stream from and to the uart
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_gap_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output ser_cfg_s serial_cfg_o,
  // straps and can side
  input wire logic mode_normal_i,
  input wire logic bus_off_i,
  output logic can_reset_o,
  output logic can_tx_valid_o,
  output logic [$clog2(WORDS)-1:0] can_tx_index_o,
  output logic [15:0] can_tx_data_o
);
  localparam int IW = $clog2(WORDS);
  localparam logic [15:0] WORDS16 = 16'(WORDS);
  localparam logic [IW-1:0] LAST_IDX = IW'(WORDS - 1);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // registers
  ctrl_s ctrl;
  ser_cfg_s ser_stored;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [31:0] interval;
  logic [15:0] table_q [WORDS];
  logic linked;
  logic sending;
  logic mode_normal;
  logic strap_taken;

  // parser state
  parse_e state;
  logic [15:0] crc;
  logic [15:0] ref_q;
  logic [15:0] cnt_q;
  logic [7:0] bcnt_q;
  logic [7:0] data_cnt;
  logic [7:0] hi_byte;
  logic [15:0] stage [WORDS];
  logic [2:0] tx_idx;
  logic [15:0] tx_crc;

  // cyclic sender
  logic [31:0] tick;
  logic [IW-1:0] send_idx;
  logic bus_off_q;

  // apb decode
  wire logic apb_access = psel_i & penable_i;
  wire logic apb_done = apb_access & pready_o;
  wire logic wr_fire = apb_done & pwrite_i;
  wire logic tbl_hit = (paddr_i >= TABLE_OFS) && (paddr_i < TABLE_OFS + 12'(4 * WORDS));
  wire logic [11:0] tbl_rel = paddr_i - TABLE_OFS;
  wire logic [IW-1:0] tbl_idx = tbl_rel[IW+1:2];
  wire logic reg_hit = (paddr_i == CTRL_OFS) || (paddr_i == SERIAL_OFS) ||
                       (paddr_i == STATUS_OFS) || (paddr_i == MASK_OFS) ||
                       (paddr_i == INTERVAL_OFS) || (paddr_i == INFO_OFS);
  wire logic wr_ok = reg_hit && (paddr_i != INFO_OFS);
  wire logic hit = pwrite_i ? wr_ok : (reg_hit | tbl_hit);
  wire logic [31:0] rd_word =
    (paddr_i == CTRL_OFS) ? {22'h0, ctrl} :
    (paddr_i == SERIAL_OFS) ? {13'h0, ser_stored} :
    (paddr_i == STATUS_OFS) ? {28'h0, status} :
    (paddr_i == MASK_OFS) ? {28'h0, mask} :
    (paddr_i == INTERVAL_OFS) ? interval :
    (paddr_i == INFO_OFS) ? {29'h0, linked, sending, mode_normal} :
    tbl_hit ? {16'h0, table_q[tbl_idx]} : 32'h0;
  wire logic [EV_W-1:0] w1c = (wr_fire && paddr_i == STATUS_OFS) ? pwdata_i[EV_W-1:0] : '0;

  // active station: default until first connection, stored after
  wire logic [7:0] station = linked ? ctrl.station_number : DEF_STATION;

  // receive byte handling
  wire logic rx_take = rx_valid_i && mode_normal && state != S_RESP;
  wire logic [15:0] next_crc = crc_byte((state == S_ADDR) ? CRC_INIT : crc, rx_data_i);
  wire logic [15:0] rx_word = ctrl.swap_en ? {rx_data_i, hi_byte} : {hi_byte, rx_data_i};
  wire logic is_startstop = (ref_q == START_STOP_REF) && (cnt_q == 16'h0001);
  wire logic [16:0] ref_end = {1'b0, ref_q} + {1'b0, cnt_q};
  wire logic span_ok = (cnt_q != 16'h0) && (ref_end <= {1'b0, WORDS16});
  wire logic bcnt_ok = ({cnt_q, 1'b0} == {9'h0, rx_data_i});
  wire logic hdr_ok = bcnt_ok && (is_startstop || span_ok);
  wire logic data_last = (data_cnt == bcnt_q - 8'h01);
  wire logic [IW-1:0] stage_idx = data_cnt[IW:1];
  wire logic crc_good = rx_take && state == S_CRC_HI && next_crc == 16'h0000;
  wire logic crc_bad = rx_take && state == S_CRC_HI && next_crc != 16'h0000;
  wire logic fmt_bad = rx_take && ((state == S_FC && rx_data_i != FC_WRITE_MULTI) ||
                                   (state == S_BCNT && !hdr_ok));

  // response bytes
  wire logic tx_fire = tx_valid_o & tx_ready_i;
  wire logic [15:0] next_tx_crc = crc_byte(tx_crc, tx_data_o);
  wire logic [2:0] nidx = tx_idx + 3'h1;
  wire logic [7:0] resp_byte =
    (nidx == 3'd1) ? FC_WRITE_MULTI :
    (nidx == 3'd2) ? ref_q[15:8] :
    (nidx == 3'd3) ? ref_q[7:0] :
    (nidx == 3'd4) ? cnt_q[15:8] :
    (nidx == 3'd5) ? cnt_q[7:0] :
    (nidx == 3'(RESP_CRC_LO)) ? next_tx_crc[7:0] : tx_crc[15:8];

  // cyclic sender and bus-off
  wire logic send_tick = sending && interval != 32'h0 && tick >= interval - 32'h1;
  wire logic bus_off_rise = bus_off_i & ~bus_off_q;
  wire logic [EV_W-1:0] ev = {bus_off_rise, fmt_bad, crc_bad, crc_good};

  // strap capture after reset release
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_taken <= 1'b0;
      mode_normal <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      mode_normal <= mode_normal_i;
    end
  end

  // apb slave: one wait state, registered answer
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_access & ~pready_o;
      prdata_o <= (apb_access && !pready_o && !pwrite_i) ? rd_word : 32'h0;
      pslverr_o <= apb_access & ~pready_o & ~hit;
    end
  end

  // software registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= CTRL_RESET;
      ser_stored <= SER_DEFAULT;
      mask <= '0;
      interval <= 32'h0;
    end else if (wr_fire) begin
      if (paddr_i == CTRL_OFS) ctrl <= pwdata_i[$bits(ctrl_s)-1:0];
      if (paddr_i == SERIAL_OFS) ser_stored <= pwdata_i[$bits(ser_cfg_s)-1:0];
      if (paddr_i == MASK_OFS) mask <= pwdata_i[EV_W-1:0];
      if (paddr_i == INTERVAL_OFS) interval <= pwdata_i;
    end
  end

  // sticky status, set wins over write-one-clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= '0;
      irq_o <= 1'b0;
    end else begin
      status <= (status & ~w1c) | ev;
      irq_o <= |(status & mask);
    end
  end

  // serial settings in force
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      linked <= 1'b0;
      serial_cfg_o <= SER_DEFAULT;
    end else begin
      if (crc_good) linked <= 1'b1;
      serial_cfg_o <= linked ? ser_stored : SER_DEFAULT;
    end
  end

  // frame parser
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= S_ADDR;
      crc <= CRC_INIT;
      ref_q <= 16'h0;
      cnt_q <= 16'h0;
      bcnt_q <= 8'h0;
      data_cnt <= 8'h0;
      hi_byte <= 8'h0;
    end else if (rx_gap_i && state != S_RESP) begin
      state <= S_ADDR;
    end else if (state == S_RESP) begin
      if (tx_fire && tx_idx == 3'(RESP_CRC_HI)) state <= S_ADDR;
    end else if (rx_take) begin
      crc <= next_crc;
      unique case (state)
        S_ADDR: state <= (rx_data_i == station) ? S_FC : S_SKIP;
        S_FC: state <= (rx_data_i == FC_WRITE_MULTI) ? S_REF_HI : S_SKIP;
        S_REF_HI: begin
          ref_q[15:8] <= rx_data_i;
          state <= S_REF_LO;
        end
        S_REF_LO: begin
          ref_q[7:0] <= rx_data_i;
          state <= S_CNT_HI;
        end
        S_CNT_HI: begin
          cnt_q[15:8] <= rx_data_i;
          state <= S_CNT_LO;
        end
        S_CNT_LO: begin
          cnt_q[7:0] <= rx_data_i;
          state <= S_BCNT;
        end
        S_BCNT: begin
          bcnt_q <= rx_data_i;
          data_cnt <= 8'h0;
          state <= hdr_ok ? S_DATA : S_SKIP;
        end
        S_DATA: begin
          if (!data_cnt[0]) hi_byte <= rx_data_i;
          data_cnt <= data_cnt + 8'h01;
          if (data_last) state <= S_CRC_LO;
        end
        S_CRC_LO: state <= S_CRC_HI;
        S_CRC_HI: state <= crc_good ? S_RESP : S_ADDR;
        S_SKIP: state <= S_SKIP;
        S_RESP: state <= S_RESP;
      endcase
    end
  end

  // staging of payload words until the check value is proven
  generate
    for (genvar j = 0; j < WORDS; j++) begin : g_word
      localparam logic [15:0] J16 = 16'(j);
      wire logic [15:0] rel = J16 - ref_q;
      wire logic in_span = !is_startstop && (ref_q <= J16) && (rel < cnt_q);
      wire logic stage_wr = rx_take && state == S_DATA && data_cnt[0] &&
                            stage_idx == IW'(j);
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stage[j] <= 16'h0;
          table_q[j] <= 16'h0;
        end else begin
          if (stage_wr) stage[j] <= rx_word;
          if (crc_good && in_span) table_q[j] <= stage[rel[IW-1:0]];
        end
      end
    end
  endgenerate

  // start and stop of cyclic sending
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sending <= 1'b0;
    end else if (crc_good && is_startstop) begin
      sending <= (stage[0] == SEND_START_VAL);
    end
  end

  // echo response
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h0;
      tx_idx <= 3'h0;
      tx_crc <= CRC_INIT;
    end else if (crc_good) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= station;
      tx_idx <= 3'h0;
      tx_crc <= CRC_INIT;
    end else if (tx_fire) begin
      tx_idx <= nidx;
      if (tx_idx < 3'(RESP_CRC_LO)) tx_crc <= next_tx_crc;
      if (tx_idx == 3'(RESP_CRC_HI)) begin
        tx_valid_o <= 1'b0;
      end else begin
        tx_data_o <= resp_byte;
      end
    end
  end

  // cyclic output of table words
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick <= 32'h0;
      send_idx <= '0;
      can_tx_valid_o <= 1'b0;
      can_tx_index_o <= '0;
      can_tx_data_o <= 16'h0;
    end else begin
      can_tx_valid_o <= send_tick;
      if (!sending || send_tick) tick <= 32'h0;
      else tick <= tick + 32'h1;
      if (send_tick) begin
        can_tx_index_o <= send_idx;
        can_tx_data_o <= table_q[send_idx];
        send_idx <= (send_idx == LAST_IDX) ? '0 : send_idx + IW'(1);
      end
    end
  end

  // automatic controller restart after bus-off
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_off_q <= 1'b0;
      can_reset_o <= 1'b0;
    end else begin
      bus_off_q <= bus_off_i;
      can_reset_o <= bus_off_rise & ctrl.busoff_rst_en;
    end
  end
endmodule

// ### test/modbus_write_port_checker.sv
// port assertions for the write-multiple handler
module modbus_write_port_checker
  import modbus_gw_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // serial
  input wire logic rx_valid_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire ser_cfg_s serial_cfg_o,
  // strap and can
  input wire logic mode_normal_i,
  input wire logic bus_off_i,
  input wire logic can_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic rst_en, seen_rx, first, mode_q;
  wire ctrl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == CTRL_OFS;
  // mirror of the restart enable and of the strap as the port takes it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_en <= 1'b0;
      seen_rx <= 1'b0;
      first <= 1'b1;
      mode_q <= 1'b0;
    end else begin
      rst_en <= ctrl_wr ? pwdata_i[0] : rst_en;
      seen_rx <= seen_rx | rx_valid_i;
      first <= 1'b0;
      mode_q <= first ? mode_normal_i : mode_q;
    end
  end
  chk_restart_soon: assert property ($rose(bus_off_i) && rst_en |-> ##[1:3] can_reset_o)
    else $error("no can restart");
  chk_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("apb answer late");
  chk_ready_once: assert property (pready_o |=> !pready_o)
    else $error("pready too long");
  chk_err_pair: assert property (pslverr_o |-> pready_o)
    else $error("lone pslverr");
  chk_data_idle: assert property (!pready_o |-> prdata_o == '0)
    else $error("stray read data");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o)) else $error("reply byte dropped");
  chk_cfg_default: assert property (!seen_rx |-> serial_cfg_o == SER_DEFAULT)
    else $error("serial settings changed early");
  chk_mode_gate: assert property (!mode_q |-> !tx_valid_o)
    else $error("reply outside operating mode");
endmodule

bind modbus_write_port modbus_write_port_checker i_modbus_write_port_checker (.clock_i,
  .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .rx_valid_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .serial_cfg_o,
  .mode_normal_i, .bus_off_i, .can_reset_o);

// ### test/modbus_master_model.sv
// serial master model feeding request bytes to the port
module modbus_master_model (
  // clock
  input wire logic clock_i,
  // request stream
  output logic rx_valid_o = 1'b0,
  output logic [7:0] rx_data_o = 8'h00,
  output logic rx_gap_o = 1'b0,
  // answer pacing
  input wire logic slow_i,
  output logic tx_ready_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow mode holds reply ready low on every other clock cycle
  always @(posedge clock_i) tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  task automatic send(input logic [7:0] q[$]);
    @(posedge clock_i) rx_gap_o <= 1'b1;
    @(posedge clock_i) rx_gap_o <= 1'b0;
    foreach (q[i]) begin
      @(posedge clock_i) rx_valid_o <= 1'b1;
      rx_data_o <= q[i];
      @(posedge clock_i) rx_valid_o <= 1'b0;
      rx_data_o <= ~q[i];
    end
  endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the write-multiple handler
module tb_top
  import modbus_gw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic mode_normal_i = 1'b1, bus_off_i = 1'b0, slow = 1'b0, rx_valid_i, rx_gap_i, tx_ready_i;
  logic pready_o, pslverr_o, irq_o, tx_valid_o, can_reset_o, can_tx_valid_o;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, seed = 32'hEB3A9A9A;
  logic [7:0] rx_data_i, tx_data_o, txq[$], q[$];
  logic [2:0] can_tx_index_o;
  logic [15:0] can_tx_data_o, wd[8];
  logic [33:0] aq[$], ae;
  ser_cfg_s serial_cfg_o;
  int error_cnt = 0, cmp_count = 0, cyc = 0, pulses = 0, restarts = 0;
  always #2 clock_i = ~clock_i;
  modbus_write_port #(.WORDS(8)) i_modbus_write_port (.clock_i, .rstn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o,
    .rx_valid_i, .rx_data_i, .rx_gap_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .serial_cfg_o,
    .mode_normal_i, .bus_off_i, .can_reset_o, .can_tx_valid_o, .can_tx_index_o, .can_tx_data_o);
  modbus_master_model i_modbus_master_model (.clock_i, .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_gap_o(rx_gap_i), .slow_i(slow), .tx_ready_o(tx_ready_i));
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic err(input string m);
    error_cnt++;
    $display("Error at %0t: %s", $time, m);
  endtask
  // e holds {check data, expected pslverr, expected data}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    aq.push_back(e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i) penable_i <= 1'b1;
    // pready is sampled at the rising edge, request held until then
    for (int i = 0; i < 50; i++) begin
      @(posedge clock_i);
      if (pready_o === 1'b1) break;
      if (i == 49) err("apb no ready");
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic frame(input logic [7:0] st, fc, bc, input logic [15:0] rf, cn, w0,
                       input logic bad, ok);
    logic [15:0] c;
    q = {st, fc, rf[15:8], rf[7:0], cn[15:8], cn[7:0]};
    c = crc16(q);
    if (ok) txq = {txq, q, c[7:0], c[15:8]};
    q.push_back(bc);
    for (int i = 0; i < cn; i++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      wd[i] = i == 0 ? w0 : seed[15:0];
      q = {q, wd[i][15:8], wd[i][7:0]};
    end
    c = crc16(q) ^ {15'h0000, bad};
    q = {q, c[7:0], c[15:8]};
    i_modbus_master_model.send(q);
    for (int i = 0; i < 400 && txq.size() != 0; i++) @(posedge clock_i);
    repeat (8) @(posedge clock_i);
  endtask
  always @(negedge clock_i) begin
    pulses += can_tx_valid_o === 1'b1;
    restarts += can_reset_o === 1'b1;
    if (can_tx_valid_o === 1'b1 && can_tx_index_o < 3'h2) begin
      cmp_count++;
      if (can_tx_data_o !== (can_tx_index_o == 3'h0 ? 16'h1234 : 16'hB2A1)) err("can word");
    end
    if (psel_i && penable_i && pready_o === 1'b1 && aq.size() != 0) begin
      ae = aq.pop_front();
      cmp_count++;
      if (pslverr_o !== ae[32] || (ae[33] && prdata_o !== ae[31:0])) err("apb answer");
    end
    if (tx_valid_o === 1'b1 && tx_ready_i) begin
      cmp_count++;
      if (txq.size() == 0 || tx_data_o !== txq.pop_front()) err("reply byte");
    end
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err("timeout");
      complete_run();
    end
  end
  task automatic complete_run();
    if (txq.size() != 0 || aq.size() != 0) err("missing answer");
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    cmp_count++;
    if (serial_cfg_o !== SER_DEFAULT || irq_o !== 1'b0) err("reset state");
    apb(1'b0, CTRL_OFS, '0, {2'b10, 32'h4});
    apb(1'b0, 12'h020, '0, {2'b01, 32'h0});
    apb(1'b1, INFO_OFS, '1, {2'b01, 32'h0});
    apb(1'b1, SERIAL_OFS, 32'h2A2D, '0);
    apb(1'b1, MASK_OFS, 32'hF, '0);
    frame(8'h01, FC_WRITE_MULTI, 8'h02, 16'h0, 16'h1, 16'h1234, 1'b0, 1'b1);
    cmp_count++;
    if (serial_cfg_o !== 19'h2A2D || irq_o !== 1'b1) err("serial settings");
    apb(1'b0, TABLE_OFS, '0, {2'b10, 32'h1234});
    apb(1'b0, STATUS_OFS, '0, {2'b10, 32'h1});
    apb(1'b1, STATUS_OFS, 32'hF, '0);
    apb(1'b1, MASK_OFS, 32'h0, '0);
    slow <= 1'b1;
    frame(8'h01, FC_WRITE_MULTI, 8'h04, 16'h6, 16'h2, seed[31:16], 1'b0, 1'b1);
    slow <= 1'b0;
    cmp_count++;
    if (irq_o !== 1'b0) err("masked irq");
    apb(1'b0, TABLE_OFS + 12'h018, '0, {18'h20000, wd[0]});
    apb(1'b0, TABLE_OFS + 12'h01C, '0, {18'h20000, wd[1]});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, STATUS_OFS, 32'hF, '0);
      frame(k == 2 ? 8'h02 : 8'h01, k == 3 ? 8'h06 : FC_WRITE_MULTI, k == 1 ? 8'h03 : 8'h02,
            16'h0, 16'h1, 16'hBEEF, k == 0, 1'b0);
      if (k < 2) apb(1'b0, STATUS_OFS, '0, {2'b10, 32'h2 << k});
      apb(1'b0, TABLE_OFS, '0, {2'b10, 32'h1234});
    end
    apb(1'b1, CTRL_OFS, 32'h7, '0);
    frame(8'h01, FC_WRITE_MULTI, 8'h02, 16'h1, 16'h1, 16'hA1B2, 1'b0, 1'b1);
    apb(1'b0, TABLE_OFS + 12'h004, '0, {2'b10, 32'hB2A1});
    apb(1'b1, STATUS_OFS, 32'hF, '0);
    bus_off_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    apb(1'b0, STATUS_OFS, '0, {2'b10, 32'h8});
    bus_off_i <= 1'b0;
    cmp_count++;
    if (restarts !== 1) err("can restart");
    apb(1'b1, INTERVAL_OFS, 32'h4, '0);
    frame(8'h01, FC_WRITE_MULTI, 8'h02, START_STOP_REF, 16'h1, SEND_START_VAL, 1'b0, 1'b1);
    apb(1'b0, INFO_OFS, '0, {2'b10, 32'h7});
    pulses = 0;
    repeat (40) @(posedge clock_i);
    cmp_count++;
    if (pulses < 9 || pulses > 11) err("cyclic rate");
    frame(8'h01, FC_WRITE_MULTI, 8'h02, START_STOP_REF, 16'h1, 16'h0001, 1'b0, 1'b1);
    apb(1'b0, INFO_OFS, '0, {2'b10, 32'h5});
    rstn_i <= 1'b0;
    mode_normal_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    frame(8'h01, FC_WRITE_MULTI, 8'h02, 16'h0, 16'h1, 16'h1234, 1'b0, 1'b0);
    apb(1'b0, INFO_OFS, '0, {2'b10, 32'h0});
    complete_run();
  end
endmodule
